// file: hw/vcd_decoder.sv
// Vendor command block decoder and sequencer for the drive target.
`timescale 1ns/10ps
module vcd_decoder
  import vcd_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire vcd_cdb_s cdb,
  input wire logic cdb_valid,
  input wire logic [3:0] id_pins,
  input wire logic bus_reset,
  output logic [3:0] target_id,
  output logic util_start,
  output logic util_resume,
  output logic [2:0] util_page,
  output logic [3:0] util_entry,
  input wire logic util_resumable,
  input wire logic util_done,
  output logic esdi_valid,
  output logic [15:0] esdi_cmd,
  output logic esdi_want_status,
  input wire logic esdi_done,
  input wire logic [3:0] esdi_flags,
  input wire logic [15:0] esdi_status,
  output logic [7:0] iface_status,
  output logic [15:0] drive_status,
  output logic drive_status_valid,
  output logic dout_req,
  input wire logic dout_done,
  output logic fmt_full,
  output logic plist_append,
  output logic plist_replace,
  output logic plist_delete,
  output logic glist_erase,
  output logic mode_save,
  input wire logic defect_done,
  output logic cmd_busy,
  output logic done_valid,
  output vcd_done_s done
);
  vcd_state_e state_r, state_nxt;
  logic [3:0] id_r, id_nxt;
  logic pend_r, pend_nxt;
  logic src_r, src_nxt;
  logic [3:0] pend_id_r, pend_id_nxt;
  logic brs1_r, brs2_r, brs3_r;
  logic [3:0] ids1_r, ids2_r, ids3_r;
  logic brst_q_r, pwr_init_r;
  logic resume_r, resume_nxt;
  logic [15:0] esdi_cmd_r, esdi_cmd_nxt;
  logic want_r, want_nxt;
  logic [7:0] ist_r, ist_nxt;
  logic [15:0] dst_r, dst_nxt;
  logic dstv_r, dstv_nxt;
  logic fmt_r, fmt_nxt;
  logic cmpl_r, cmpl_nxt;
  logic [2:0] page_r, page_nxt;
  logic [3:0] entry_r, entry_nxt;
  vcd_done_s done_r, done_nxt;
  logic bus_rst_seen;
  logic [3:0] pins_ok;

  // Illegal field answer, shared by the utility and defect paths.
  function automatic vcd_done_s bad_field();
    vcd_done_s d;
    d.status = VCD_ST_CHECK;
    d.sense_key = VCD_KEY_ILLEGAL;
    d.asc = VCD_ASC_BAD_FIELD;
    return d;
  endfunction

  // Three-flop pin chains, left out of reset so pins are settled at release.
  always_ff @(posedge clock)
  begin
    ids1_r <= id_pins;
    ids2_r <= ids1_r;
    ids3_r <= ids2_r;
    brs1_r <= bus_reset;
    brs2_r <= brs1_r;
    brs3_r <= brs2_r;
  end
  assign pins_ok = (ids2_r == ids3_r) ? ids3_r : id_r;
  assign bus_rst_seen = brs2_r && brs3_r && !brst_q_r;

  // Bus reset edge memory and power-up load marker.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      brst_q_r <= 1'b0;
      pwr_init_r <= 1'b1;
    end
    else
    begin
      brst_q_r <= brs2_r && brs3_r;
      pwr_init_r <= 1'b0;
    end
  end

  // Target ID and pending change.
  always_comb
  begin
    id_nxt = id_r;
    pend_nxt = pend_r;
    src_nxt = src_r;
    pend_id_nxt = pend_id_r;
    if (pwr_init_r)
      id_nxt = pins_ok;
    else if (bus_rst_seen)
    begin
      if (pend_r && src_r)
        id_nxt = pend_id_r;
      else
        id_nxt = pins_ok;
      pend_nxt = 1'b0;
    end
    if (state_r == VCD_IDLE && cdb_valid && cdb.b0 == VCD_OP_CHANGE_ID)
    begin
      pend_nxt = 1'b1;
      src_nxt = cdb.b4[VCD_IDSRC_BIT];
      pend_id_nxt = cdb.b4[3:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      id_r <= VCD_ID_RESET;
      pend_r <= 1'b0;
      src_r <= 1'b0;
      pend_id_r <= VCD_ID_RESET;
    end
    else
    begin
      id_r <= id_nxt;
      pend_r <= pend_nxt;
      src_r <= src_nxt;
      pend_id_r <= pend_id_nxt;
    end
  end

  // Command sequencer.
  always_comb
  begin
    state_nxt = state_r;
    esdi_cmd_nxt = esdi_cmd_r;
    want_nxt = want_r;
    ist_nxt = ist_r;
    dst_nxt = dst_r;
    dstv_nxt = dstv_r;
    fmt_nxt = fmt_r;
    cmpl_nxt = cmpl_r;
    page_nxt = page_r;
    entry_nxt = entry_r;
    resume_nxt = resume_r;
    done_nxt = done_r;
    unique case (state_r)
      VCD_IDLE:
        if (cdb_valid)
        begin
          done_nxt = '{VCD_ST_GOOD, 4'h0, 8'h00};
          state_nxt = VCD_DONE;
          dstv_nxt = 1'b0;
          if (cdb.b0 == VCD_OP_UTILITY)
          begin
            page_nxt = cdb.b2[2:0];
            entry_nxt = cdb.b3[3:0];
            resume_nxt = cdb.b1[VCD_RST_BIT];
            if (cdb.b2[2:0] != VCD_PAGE_LO && cdb.b2[2:0] != VCD_PAGE_HI)
              done_nxt = bad_field();
            else if (cdb.b1[VCD_RST_BIT] && !util_resumable)
              done_nxt = bad_field();
            else if (cdb.b1[VCD_EXE_BIT] || cdb.b1[VCD_RST_BIT])
              state_nxt = VCD_UTIL;
          end
          else if (cdb.b0 == VCD_OP_PASSTHRU)
          begin
            esdi_cmd_nxt = {cdb.b2, cdb.b3};
            want_nxt = cdb.b1[VCD_STAT_BIT];
            state_nxt = VCD_ESDI;
          end
          else if (cdb.b0 == VCD_OP_DEFECT)
          begin
            fmt_nxt = cdb.b1[VCD_FMT_BIT];
            cmpl_nxt = cdb.b1[VCD_CMPL_BIT];
            if (!cdb.b1[VCD_FMT_BIT])
              state_nxt = VCD_DFCT;
            else if (cdb.b1[2:0] != VCD_DLF_BLOCK &&
                     cdb.b1[2:0] != VCD_DLF_INDEX &&
                     cdb.b1[2:0] != VCD_DLF_PHYS)
              done_nxt = bad_field();
            else
              state_nxt = VCD_DOUT;
          end
        end
      VCD_UTIL:
        if (util_done)
          state_nxt = VCD_DONE;
      VCD_ESDI:
        // No timeout here: a command that never ends hangs the target.
        if (esdi_done)
        begin
          ist_nxt = {4'h0, esdi_flags};
          dst_nxt = want_r ? esdi_status : 16'h0000;
          dstv_nxt = want_r;
          state_nxt = VCD_DONE;
        end
      VCD_DOUT:
        if (dout_done)
          state_nxt = VCD_DFCT;
      VCD_DFCT:
        if (defect_done)
          state_nxt = VCD_DONE;
      VCD_DONE:
        state_nxt = VCD_IDLE;
      default:
        state_nxt = VCD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_r <= VCD_IDLE;
      esdi_cmd_r <= 16'h0000;
      want_r <= 1'b0;
      ist_r <= 8'h00;
      dst_r <= 16'h0000;
      dstv_r <= 1'b0;
      fmt_r <= 1'b0;
      cmpl_r <= 1'b0;
      page_r <= 3'h0;
      entry_r <= 4'h0;
      resume_r <= 1'b0;
      done_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      esdi_cmd_r <= esdi_cmd_nxt;
      want_r <= want_nxt;
      ist_r <= ist_nxt;
      dst_r <= dst_nxt;
      dstv_r <= dstv_nxt;
      fmt_r <= fmt_nxt;
      cmpl_r <= cmpl_nxt;
      page_r <= page_nxt;
      entry_r <= entry_nxt;
      resume_r <= resume_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs; the utility reads its parameters from the write buffer itself.
  assign target_id = id_r;
  assign util_page = page_r;
  assign util_entry = entry_r;
  assign util_start = state_r == VCD_UTIL;
  assign util_resume = state_r == VCD_UTIL && resume_r;
  assign esdi_valid = state_r == VCD_ESDI;
  assign esdi_cmd = esdi_cmd_r;
  assign esdi_want_status = want_r;
  assign iface_status = ist_r;
  assign drive_status = dst_r;
  assign drive_status_valid = dstv_r;
  assign dout_req = state_r == VCD_DOUT;
  // Delete (no new list) and replace both reformat; append does not.
  assign plist_delete = state_r == VCD_DFCT && !fmt_r;
  assign plist_replace = state_r == VCD_DFCT && fmt_r && cmpl_r;
  assign plist_append = state_r == VCD_DFCT && fmt_r && !cmpl_r;
  assign fmt_full = plist_delete || plist_replace;
  assign glist_erase = state_r == VCD_DFCT;
  assign mode_save = state_r == VCD_DFCT && defect_done;
  assign cmd_busy = state_r != VCD_IDLE;
  assign done_valid = state_r == VCD_DONE;
  assign done = done_r;

  // Pending ID is applied on the bus reset edge, not before.
  id_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !bus_rst_seen && !pwr_init_r |=> target_id == $past(target_id))
    else $error("Target ID changed without bus reset.");
  id_cmd_a: assert property (@(posedge clock) disable iff (!reset_n)
    bus_rst_seen && pend_r && src_r && !pwr_init_r
    |=> target_id == $past(pend_id_r))
    else $error("Commanded ID not applied.");
  page_bad_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_r == VCD_IDLE && cdb_valid && cdb.b0 == VCD_OP_UTILITY &&
    cdb.b2[2:1] != 2'b11 |=> done_valid && done.status == VCD_ST_CHECK)
    else $error("Bad page not rejected.");
  esdi_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
    esdi_valid |-> esdi_cmd == $past(esdi_cmd, 1) || $rose(esdi_valid))
    else $error("Drive command changed in flight.");
  stat_top_a: assert property (@(posedge clock) disable iff (!reset_n)
    done_valid |-> iface_status[7:4] == 4'h0)
    else $error("Undefined status bits not zero.");
  glist_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(state_r == VCD_DFCT) |-> glist_erase)
    else $error("Grown list not erased.");
  append_a: assert property (@(posedge clock) disable iff (!reset_n)
    plist_append |-> !fmt_full)
    else $error("Append reformatted media.");
  skip_dout_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_r == VCD_IDLE && cdb_valid && cdb.b0 == VCD_OP_DEFECT &&
    !cdb.b1[VCD_FMT_BIT] |=> !dout_req ##1 !dout_req)
    else $error("Data-out taken without format data.");
  resume_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(util_start) |-> util_resume == $past(cdb.b1[VCD_RST_BIT]))
    else $error("Restart flag not passed to the utility.");
endmodule // vcd_decoder

// file: hw/vcd_pkg.sv
// Package with command codes, field positions and types for the decoder.
package vcd_pkg;
  // Opcodes of the four vendor commands.
  localparam logic [7:0] VCD_OP_CHANGE_ID = 8'hC2;
  localparam logic [7:0] VCD_OP_UTILITY = 8'hFE;
  localparam logic [7:0] VCD_OP_PASSTHRU = 8'hEF;
  localparam logic [7:0] VCD_OP_DEFECT = 8'hFD;
  // Supported ROM pages.
  localparam logic [2:0] VCD_PAGE_LO = 3'h6;
  localparam logic [2:0] VCD_PAGE_HI = 3'h7;
  // Field positions.
  localparam int VCD_IDSRC_BIT = 4;
  localparam int VCD_EXE_BIT = 0;
  localparam int VCD_RST_BIT = 2;
  localparam int VCD_STAT_BIT = 0;
  localparam int VCD_FMT_BIT = 4;
  localparam int VCD_CMPL_BIT = 3;
  // Defect list formats accepted.
  localparam logic [2:0] VCD_DLF_BLOCK = 3'h0;
  localparam logic [2:0] VCD_DLF_INDEX = 3'h4;
  localparam logic [2:0] VCD_DLF_PHYS = 3'h5;
  // Status and sense codes.
  localparam logic [7:0] VCD_ST_GOOD = 8'h00;
  localparam logic [7:0] VCD_ST_CHECK = 8'h02;
  localparam logic [3:0] VCD_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] VCD_ASC_BAD_FIELD = 8'h24;
  // Reset values.
  localparam logic [3:0] VCD_ID_RESET = 4'h0;

  // Command block as received; byte 0 is the opcode.
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } vcd_cdb_s;

  // Command completion answer.
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } vcd_done_s;

  typedef enum logic [2:0] {
    VCD_IDLE = 3'b000,
    VCD_UTIL = 3'b001,
    VCD_ESDI = 3'b010,
    VCD_DOUT = 3'b011,
    VCD_DFCT = 3'b100,
    VCD_DONE = 3'b101
  } vcd_state_e;
endpackage

// file: testbench/vcd_far_model.sv
// Behavioural far side: utility engine, drive interface and defect engine.
`timescale 1ns/10ps
module vcd_far_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] lat,
  input wire logic util_start,
  input wire logic esdi_valid,
  input wire logic dout_req,
  input wire logic glist_erase,
  output logic util_done,
  output logic esdi_done,
  output logic dout_done,
  output logic defect_done
);
  logic [3:0] req;
  logic [3:0] done_r;
  logic [7:0] cnt_r [4];
  // The defect engine is busy exactly while the grown list is being erased.
  assign req = {glist_erase, dout_req, esdi_valid, util_start};
  // One pulse per request, lat+1 cycles after it rises; the count then parks above lat.
  // Any lat up to 248 is legal: the drive interface has no timeout, but send waits at most 500 cycles.
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < 4; i++)
    begin
      done_r[i] <= reset_n && req[i] && cnt_r[i] == lat;
      if (!reset_n || !req[i])
        cnt_r[i] <= 8'h00;
      else if (cnt_r[i] <= lat)
        cnt_r[i] <= cnt_r[i] + 8'h01;
    end
  end
  // Buffer parameters are taken as preloaded; the list arrives in data-out.
  assign {defect_done, dout_done, esdi_done, util_done} = done_r;
endmodule // vcd_far_model

// file: testbench/tb_top.sv
// Self-checking bench for the vendor command decoder.
`timescale 1ns/10ps
module tb_top;
  import vcd_pkg::*;
  logic clock, reset_n, cdb_valid, bus_reset, util_resumable, util_start;
  logic util_resume, util_done, esdi_valid, esdi_want_status, esdi_done;
  logic drive_status_valid, dout_req, dout_done, fmt_full, plist_append;
  logic plist_replace, plist_delete, glist_erase, mode_save, defect_done;
  logic cmd_busy, done_valid;
  logic [3:0] id_pins, target_id, util_entry, esdi_flags;
  logic [2:0] util_page;
  logic [15:0] esdi_cmd, esdi_status, drive_status;
  logic [7:0] iface_status, lat, rnd;
  logic [8:0] seen;
  logic [7:0] cap_util;
  logic [16:0] cap_cmd;
  logic [7:0] dtab [6] = '{8'h0F, 8'h10, 8'h1D, 8'h14, 8'h12, 8'h1B};
  vcd_cdb_s cdb;
  vcd_done_s done;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  vcd_decoder u_vcd_decoder (.clock, .reset_n, .cdb, .cdb_valid, .id_pins,
    .bus_reset, .target_id, .util_start, .util_resume, .util_page,
    .util_entry, .util_resumable, .util_done, .esdi_valid, .esdi_cmd,
    .esdi_want_status, .esdi_done, .esdi_flags, .esdi_status, .iface_status,
    .drive_status, .drive_status_valid, .dout_req, .dout_done, .fmt_full,
    .plist_append, .plist_replace, .plist_delete, .glist_erase, .mode_save,
    .defect_done, .cmd_busy, .done_valid, .done);
  vcd_far_model u_vcd_far_model (.clock, .reset_n, .lat, .util_start,
    .esdi_valid, .dout_req, .glist_erase, .util_done, .esdi_done, .dout_done,
    .defect_done);
  // Free-running 8 ns clock.
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Sticky record of outputs during a command, and the hang limit.
  always @(posedge clock)
  begin
    seen |= {util_start, esdi_valid, dout_req, fmt_full, plist_append,
      plist_replace, plist_delete, glist_erase, mode_save};
    if (util_start)
      cap_util = {util_resume, util_page, util_entry};
    if (esdi_valid)
      cap_cmd = {esdi_want_status, esdi_cmd};
    cycles++;
    if (cycles == 32'h0000_4E20)
    begin
      errors++;
      results();
    end
  end
  // Next state of the stimulus shift register.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Whether a utility command must be refused.
  function automatic logic util_bad(input logic [7:0] b1,
    input logic [2:0] pg, input logic res);
    return (b1[2] && !res) || (pg != VCD_PAGE_LO && pg != VCD_PAGE_HI);
  endfunction
  // Outputs a defect command must show; none at all means refused.
  function automatic logic [8:0] defect_seen(input logic [7:0] b1);
    if (!b1[4])
      return 9'h027;
    if (!(b1[2:0] inside {VCD_DLF_BLOCK, VCD_DLF_INDEX, VCD_DLF_PHYS}))
      return 9'h000;
    return b1[3] ? 9'h06B : 9'h053;
  endfunction
  task automatic chk(input string name, input logic [19:0] exp,
    input logic [19:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results;
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One command: present it for one edge, wait for the answer, compare.
  task automatic send(input vcd_cdb_s c, input logic bad,
    input logic [8:0] exp_seen);
    int n;
    @(posedge clock);
    #1;
    seen = 9'h000;
    cdb = c;
    cdb_valid = 1'b1;
    @(posedge clock);
    #1;
    cdb_valid = 1'b0;
    n = 0;
    while (done_valid !== 1'b1 && n < 500)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("done_valid", 1'b1, done_valid);
    if (bad)
      chk("done", {VCD_ST_CHECK, VCD_KEY_ILLEGAL, VCD_ASC_BAD_FIELD}, done);
    else
      chk("status", VCD_ST_GOOD, done.status);
    chk("activity", exp_seen, seen);
  endtask
  // Holds the bus reset past its synchroniser, then checks the new ID.
  task automatic breset(input logic [3:0] exp);
    bus_reset = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    bus_reset = 1'b0;
    chk("target_id", exp, target_id);
  endtask
  // Main sequence.
  initial
  begin
    logic [3:0] old;
    logic [3:0] ent;
    logic [7:0] b1;
    logic [2:0] pg;
    logic bad;
    {reset_n, cdb_valid, bus_reset, util_resumable} = 4'h0;
    {cdb, lat, esdi_flags, esdi_status} = '0;
    rnd = 8'h4F;
    id_pins = 4'hA;
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("reset_id", 4'hA, target_id);
    // Deferred ID change from both sources, reserved bits randomised.
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      old = target_id;
      id_pins = rnd[7:4] ^ 4'h5;
      send({VCD_OP_CHANGE_ID, 24'h0, rnd[7:5], i[0], rnd[3:0]}, 1'b0, 9'h0);
      repeat (4) @(posedge clock);
      #1;
      chk("id_held", old, target_id);
      breset(i[0] ? rnd[3:0] : id_pins);
    end
    // A reset stands for power restore and drops the pending ID.
    send({VCD_OP_CHANGE_ID, 24'h0, 4'h1, ~id_pins}, 1'b0, 9'h0);
    reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("power_id", id_pins, target_id);
    breset(id_pins);
    // Every page with the run flag, then restart refused and resumed.
    for (int i = 0; i < 11; i++)
    begin
      rnd = lfsr(rnd);
      lat = {3'h0, rnd[4:0]};
      pg = i < 8 ? i[2:0] : VCD_PAGE_LO;
      b1 = i < 8 ? 8'h01 : i == 8 ? 8'h04 : i == 9 ? 8'h05 : 8'h00;
      ent = i == 6 ? 4'hF : i == 7 ? 4'h0 : rnd[3:0];
      util_resumable = i != 8;
      bad = util_bad(b1, pg, util_resumable);
      send({VCD_OP_UTILITY, b1, 5'h0, pg, 4'h0, ent, 8'h0}, bad,
        (bad || b1[2:0] == 3'h0) ? 9'h000 : 9'h100);
      if (!bad && b1[2:0] != 3'h0)
        chk("util_sel", {b1[2], pg, ent}, cap_util);
    end
    // Drive passthrough, prompt and slow, with and without status bytes.
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      lat = i[1] ? 8'h3C : 8'h00;
      esdi_flags = rnd[3:0];
      esdi_status = {~rnd, rnd};
      send({VCD_OP_PASSTHRU, 7'h0, i[0], rnd, ~rnd, 8'h0}, 1'b0, 9'h080);
      esdi_status = ~esdi_status;
      chk("esdi_cmd", {i[0], rnd, ~rnd}, cap_cmd);
      chk("iface_status", {4'h0, rnd[3:0]}, iface_status);
      if (i[0])
        chk("drive_status", {1'b1, ~rnd, rnd},
          {drive_status_valid, drive_status});
      else
        chk("drive_status_valid", 1'b0, drive_status_valid);
    end
    // Delete with ignored options, append, replace, reserved formats.
    lat = 8'h05;
    foreach (dtab[i])
      send({VCD_OP_DEFECT, dtab[i], 24'h0}, defect_seen(dtab[i]) == 9'h0,
        defect_seen(dtab[i]));
    results();
  end
endmodule // tb_top
